//--- pkg/fsmc_map.svh
// register map, field positions, reset values and timing counts of the fan control block
`ifndef FSMC_MAP_SVH
`define FSMC_MAP_SVH

// register offsets
`define FSMC_OFS_CFG1     8'h00
`define FSMC_OFS_READING  8'h08
`define FSMC_OFS_TARGET   8'h10
`define FSMC_OFS_CHAR1    8'h20
`define FSMC_OFS_DUTYSET  8'h22
`define FSMC_OFS_FILTER   8'h23
`define FSMC_OFS_STATUS   8'h40
`define FSMC_OFS_MASK     8'h41

// main configuration fields
`define FSMC_CFG1_AUTO    7
`define FSMC_CFG1_RPM     5
`define FSMC_CFG1_FLTEN   4
`define FSMC_CFG1_INVERT  3

// filter register fields
`define FSMC_FLT_SPINDIS  7
`define FSMC_FLT_RAMP_HI  6
`define FSMC_FLT_RAMP_LO  5
`define FSMC_FLT_RATE_HI  4
`define FSMC_FLT_RATE_LO  2
`define FSMC_FLT_EN       0

// fan characteristics: speed range field
`define FSMC_CHR_RANGE_HI 7
`define FSMC_CHR_RANGE_LO 6

// status and mask bits
`define FSMC_ST_MEAS      0
`define FSMC_ST_FAIL      1

// reset values
`define FSMC_CFG1_RST     8'h00
`define FSMC_TARGET_RST   8'hFF
`define FSMC_CHAR1_RST    8'h00
`define FSMC_DUTYSET_RST  8'h00
`define FSMC_FILTER_RST   8'h10
`define FSMC_MASK_RST     2'h0

// timing
`define FSMC_CLK_HZ       10000000
`define FSMC_OSC_HZ       11250
`define FSMC_OSC_CYCLES   (`FSMC_CLK_HZ / `FSMC_OSC_HZ)
`define FSMC_SLOT_CYCLES  4
`define FSMC_SLOTS        8'd240
`define FSMC_RPM_FLOOR    8'd180
`define FSMC_TACH_MAX     8'hFF

`endif

//--- pkg/fsmc_pkg.sv
// types shared by the fan control block
package fsmc_pkg;

  // tach measurement phases
  typedef enum logic [2:0] {
    TM_ARM   = 3'b001,
    TM_SYNC  = 3'b010,
    TM_COUNT = 3'b100
  } fsmc_tach_st_t;

  typedef struct packed {
    fsmc_tach_st_t state;
    logic          tachPrev;
    logic          edgeSeen;
    logic [7:0]    cnt;
    logic [7:0]    result;
    logic          done;
  } fsmc_tach_t;

  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] target;
    logic [7:0] char1;
    logic [7:0] dutySet;
    logic [7:0] filter;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] reading;
    logic [7:0] rdData;
    logic [7:0] duty;
    logic [7:0] slotCnt;
    logic [2:0] slotDiv;
    logic [9:0] oscDiv;
    logic [2:0] rangeDiv;
    logic       gateTick;
    logic       pwm;
    logic       irq;
  } fsmc_ctl_t;

endpackage

//--- src/fsmc_tach_meter.sv
// tach period meter: counts gated clock ticks over two tach periods
`timescale 1ns/1ps
`default_nettype none
`include "fsmc_map.svh"

module fsmc_tach_meter (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       gateTick,
  input  wire logic       tachIn,
  input  wire logic       measEn,
  output logic [7:0]      count,
  output logic            done
);

  fsmc_pkg::fsmc_tach_t q;
  fsmc_pkg::fsmc_tach_t d;
  logic rise;

  assign rise  = tachIn && !q.tachPrev;
  assign count = q.result;
  assign done  = q.done;

  // phase sequencing and period counting
  always_comb begin
    d          = q;
    d.tachPrev = tachIn;
    d.done     = 1'b0;
    case (q.state)
      fsmc_pkg::TM_ARM: begin
        if (measEn && rise) begin
          d.state = fsmc_pkg::TM_SYNC;
        end
      end
      // R17 start on second edge
      fsmc_pkg::TM_SYNC: begin
        if (rise) begin
          d.state    = fsmc_pkg::TM_COUNT;
          d.cnt      = 8'h00;
          d.edgeSeen = 1'b0;
        end
      end
      fsmc_pkg::TM_COUNT: begin
        if (rise && q.edgeSeen) begin
          // R17 stop on fourth edge
          d.result = q.cnt;
          d.done   = 1'b1;
          d.state  = fsmc_pkg::TM_ARM;
        end else if (gateTick && q.cnt == `FSMC_TACH_MAX) begin
          // R11 saturate at full scale
          d.result = `FSMC_TACH_MAX;
          d.done   = 1'b1;
          d.state  = fsmc_pkg::TM_ARM;
        end else begin
          if (rise) begin
            d.edgeSeen = 1'b1;
          end
          if (gateTick) begin
            d.cnt = q.cnt + 8'h01;
          end
        end
      end
      default: begin
        d.state = fsmc_pkg::TM_ARM;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '{state: fsmc_pkg::TM_ARM, default: '0};
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_second_rise;
    q.state == fsmc_pkg::TM_SYNC && rise;
  endsequence

  property p_tach_start;
    s_second_rise |=> q.state == fsmc_pkg::TM_COUNT && q.cnt == 8'h00 && !q.edgeSeen;
  endproperty
  a_tach_start: assert property (p_tach_start) else $error("count did not start on second edge"); // R17

  property p_tach_sat;
    q.state == fsmc_pkg::TM_COUNT && q.cnt == 8'hFF && gateTick && !(rise && q.edgeSeen)
      |=> done && count == 8'hFF && q.state == fsmc_pkg::TM_ARM;
  endproperty
  a_tach_sat: assert property (p_tach_sat) else $error("counter did not saturate at full scale"); // R11

endmodule
`default_nettype wire

//--- src/fsmc_fan_control.sv
// fan drive mode control: register file, duty selection, rpm loop and pwm output
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fsmc_map.svh"

// Functional notes
// R1 - software programs loop settings, then filter, then auto
// R2 - auto bit clear hands duty to software
// R3 - software duty mode uses duty setting register
// R4 - four-bit code gives sixteen fifteenth steps
// R5 - rpm bit selects closed-loop speed mode
// R6 - target limit becomes tach count target
// R7 - slower fan raises duty, faster lowers
// R8 - software computes target count from rpm
// R9 - software uses speed range two in rpm
// R10 - rpm mode fails only at count 255
// R11 - tach counter saturates at 255, interrupts
// R12 - rpm loop regulates from 75 to 100 percent
// R13 - software avoids targets below 53 percent speed
// R14 - software scales for three or four pulses
// R15 - filter register holds spin, ramp, rate, enable
// R16 - speed range divides gating clock 1,2,4,8
// R17 - measure from second to fourth tach edge
// R18 - rpm duty steps once per measurement
module fsmc_fan_control (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic [7:0]      rdData,
  input  wire logic       tachIn,
  input  wire logic [7:0] autoDuty,
  input  wire logic       autoUpdate,
  output logic            pwmOut,
  output logic            irq
);

  fsmc_pkg::fsmc_ctl_t q;
  fsmc_pkg::fsmc_ctl_t d;
  logic [7:0] measCount;
  logic       measDone;
  logic       autoMode;
  logic       rpmMode;
  logic       filterOn;
  logic       failEvt;
  logic [7:0] rampStep;

  // four-bit code to duty slots, sixteen slots per step
  function automatic logic [7:0] dutyFromCode(input logic [7:0] code);
    dutyFromCode = {code[3:0], 4'h0};
  endfunction

  // register read decode
  function automatic logic [7:0] readReg(input fsmc_pkg::fsmc_ctl_t s, input logic [7:0] a);
    case (a)
      `FSMC_OFS_CFG1:    readReg = s.cfg1;
      `FSMC_OFS_READING: readReg = s.reading;
      `FSMC_OFS_TARGET:  readReg = s.target;
      `FSMC_OFS_CHAR1:   readReg = s.char1;
      `FSMC_OFS_DUTYSET: readReg = s.dutySet;
      `FSMC_OFS_FILTER:  readReg = {s.filter[7:2], 1'b0, s.filter[0]};
      `FSMC_OFS_STATUS:  readReg = {6'h00, s.status};
      `FSMC_OFS_MASK:    readReg = {6'h00, s.mask};
      default:           readReg = 8'h00;
    endcase
  endfunction

  assign autoMode = q.cfg1[`FSMC_CFG1_AUTO];
  // R5 rpm bit selects closed loop
  assign rpmMode  = !autoMode && q.cfg1[`FSMC_CFG1_RPM];
  assign filterOn = q.filter[`FSMC_FLT_EN];
  assign rdData   = q.rdData;
  assign pwmOut   = q.pwm;
  assign irq      = q.irq;

  // R15 ramp code to step of 1, 2, 4 or 8 slots
  assign rampStep = 8'h01 << q.filter[`FSMC_FLT_RAMP_HI:`FSMC_FLT_RAMP_LO];

  // R10 fail only at full scale in rpm mode
  assign failEvt = measDone && (rpmMode ? (measCount == `FSMC_TACH_MAX) : (measCount > q.target));

  fsmc_tach_meter u_meter (
    .mclk     (mclk),
    .reset    (reset),
    .gateTick (q.gateTick),
    .tachIn   (tachIn),
    .measEn   (q.duty != 8'h00),
    .count    (measCount),
    .done     (measDone)
  );

  // next state of registers, dividers, duty and pwm
  always_comb begin
    logic       oscTick;
    logic       slotTick;
    logic [1:0] setBits;
    logic [1:0] clrBits;
    logic [2:0] rangeMask;
    logic [8:0] upSum;
    oscTick   = 1'b0;
    slotTick  = 1'b0;
    setBits   = 2'h0;
    clrBits   = 2'h0;
    rangeMask = 3'h0;
    upSum     = 9'h000;
    d         = q;

    // register writes
    if (wrStb) begin
      case (addr)
        `FSMC_OFS_CFG1:    d.cfg1    = wrData;
        `FSMC_OFS_TARGET:  d.target  = wrData;
        `FSMC_OFS_CHAR1:   d.char1   = wrData;
        `FSMC_OFS_DUTYSET: d.dutySet = wrData;
        `FSMC_OFS_FILTER:  d.filter  = {wrData[7:2], 1'b0, wrData[0]};
        `FSMC_OFS_STATUS:  clrBits   = wrData[1:0];
        `FSMC_OFS_MASK:    d.mask    = wrData[1:0];
        default:           d.cfg1    = q.cfg1;
      endcase
    end

    // read data stands only in the cycle after the strobe
    d.rdData = rdStb ? readReg(q, addr) : 8'h00;

    // base 11.25 kHz oscillator tick
    oscTick = (q.oscDiv == 10'(`FSMC_OSC_CYCLES - 1));
    d.oscDiv = oscTick ? 10'h000 : q.oscDiv + 10'h001;

    // R16 speed range divides the gating clock
    rangeMask = 3'((4'h1 << q.char1[`FSMC_CHR_RANGE_HI:`FSMC_CHR_RANGE_LO]) - 4'h1);
    d.gateTick = oscTick && ((q.rangeDiv & rangeMask) == 3'h0);
    if (oscTick) begin
      d.rangeDiv = q.rangeDiv + 3'h1;
    end

    // pwm slot timebase, 240 slots per period
    slotTick = (q.slotDiv == 3'(`FSMC_SLOT_CYCLES - 1));
    d.slotDiv = slotTick ? 3'h0 : q.slotDiv + 3'h1;
    if (slotTick) begin
      d.slotCnt = (q.slotCnt == `FSMC_SLOTS - 8'h01) ? 8'h00 : q.slotCnt + 8'h01;
    end

    // duty source selection
    if (autoMode) begin
      if (!filterOn) begin
        d.duty = (autoDuty > `FSMC_SLOTS) ? `FSMC_SLOTS : autoDuty;
      end else if (autoUpdate) begin
        // R15 filtered ramp toward the loop's duty
        upSum = {1'b0, q.duty} + {1'b0, rampStep};
        if (autoDuty > q.duty) begin
          d.duty = (upSum > {1'b0, autoDuty}) ? autoDuty : upSum[7:0];
        end else if (autoDuty < q.duty) begin
          d.duty = (q.duty < autoDuty + rampStep) ? autoDuty : q.duty - rampStep;
        end
        if (d.duty > `FSMC_SLOTS) begin
          d.duty = `FSMC_SLOTS;
        end
      end
    end else if (rpmMode) begin
      // R12 hold duty inside the 75 to 100 percent band
      if (q.duty < `FSMC_RPM_FLOOR) begin
        d.duty = `FSMC_RPM_FLOOR;
      end else if (measDone) begin
        // R6 R7 R18 one step per measurement against target count
        if (measCount > q.target && q.duty < `FSMC_SLOTS) begin
          d.duty = q.duty + 8'h01;
        end else if (measCount < q.target && q.duty > `FSMC_RPM_FLOOR) begin
          d.duty = q.duty - 8'h01;
        end
      end
    end else begin
      // R2 R3 R4 software code drives the duty
      d.duty = dutyFromCode(q.dutySet);
    end

    // pwm output, optionally inverted
    d.pwm = (q.slotCnt < q.duty) ^ q.cfg1[`FSMC_CFG1_INVERT];

    // R11 latch reading and raise events
    if (measDone) begin
      d.reading = measCount;
    end
    setBits[`FSMC_ST_MEAS] = measDone;
    setBits[`FSMC_ST_FAIL] = failEvt;
    d.status = (q.status & ~clrBits) | setBits;
    d.irq    = |(d.status & d.mask);
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q         <= '0;
      q.cfg1    <= `FSMC_CFG1_RST;
      q.target  <= `FSMC_TARGET_RST;
      q.char1   <= `FSMC_CHAR1_RST;
      q.dutySet <= `FSMC_DUTYSET_RST;
      q.filter  <= `FSMC_FILTER_RST;
      q.mask    <= `FSMC_MASK_RST;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_auto_exit;
    $fell(autoMode) && !q.cfg1[`FSMC_CFG1_RPM] |=> q.duty == dutyFromCode($past(q.dutySet));
  endproperty
  a_auto_exit: assert property (p_auto_exit) else $error("software did not take over duty"); // R2

  property p_sw_duty;
    !autoMode && !q.cfg1[`FSMC_CFG1_RPM] |=> q.duty == {$past(q.dutySet[3:0]), 4'h0};
  endproperty
  a_sw_duty: assert property (p_sw_duty) else $error("duty does not follow duty setting"); // R3

  property p_code_full;
    !autoMode && !q.cfg1[`FSMC_CFG1_RPM] && q.dutySet[3:0] == 4'hF |=> q.duty == 8'd240;
  endproperty
  a_code_full: assert property (p_code_full) else $error("code F is not full duty"); // R4

  sequence s_slow_meas;
    rpmMode && q.duty >= 8'd180 && q.duty < 8'd240 && measDone && measCount > q.target;
  endsequence

  property p_rpm_up;
    s_slow_meas |=> q.duty == $past(q.duty) + 8'h01;
  endproperty
  a_rpm_up: assert property (p_rpm_up) else $error("slow fan did not raise duty"); // R7

  property p_rpm_down;
    rpmMode && q.duty > 8'd180 && measDone && measCount < q.target |=> q.duty == $past(q.duty) - 8'h01;
  endproperty
  a_rpm_down: assert property (p_rpm_down) else $error("fast fan did not lower duty"); // R7

  property p_rpm_fail;
    rpmMode && measDone |=> q.status[1] == ($past(measCount) == 8'hFF ||
      ($past(q.status[1]) && !($past(wrStb) && $past(addr) == `FSMC_OFS_STATUS && $past(wrData[1]))));
  endproperty
  a_rpm_fail: assert property (p_rpm_fail) else $error("rpm failure flag not tied to full count"); // R10

  property p_rpm_band;
    rpmMode && $past(rpmMode) |=> q.duty >= 8'd180 && q.duty <= 8'd240;
  endproperty
  a_rpm_band: assert property (p_rpm_band) else $error("rpm duty left its band"); // R12

  property p_filter_ramp;
    autoMode && filterOn && autoUpdate && autoDuty <= 8'd240 && {1'b0, autoDuty} >= {1'b0, q.duty} + {1'b0, rampStep}
      |=> q.duty == $past(q.duty) + $past(rampStep);
  endproperty
  a_filter_ramp: assert property (p_filter_ramp) else $error("filtered ramp step wrong"); // R15

  property p_irq;
    !wrStb && !measDone |=> irq == $past(|(q.status & q.mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output not tied to status"); // R11

endmodule
`default_nettype wire

//--- tb/fsmc_fan_model.sv
// cooling fan model: tach square wave at a set period, held low when stalled
`timescale 1ns/1ps
`default_nettype none
module fsmc_fan_model (
  input  wire logic        mclk,
  input  wire logic        run,
  input  wire logic [15:0] halfPer,
  output logic             tach
);
  logic [15:0] cnt;
  initial begin
    tach = 1'b0;
    cnt = 16'h0000;
  end
  // toggle tach each half period while the rotor turns
  // two tach pulses per revolution
  always @(posedge mclk) begin
    if (!run) begin
      tach <= 1'b0;
      cnt <= 16'h0000;
    end else if (cnt >= halfPer - 16'h0001) begin
      tach <= ~tach;
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- tb/fsmc_fan_control_tb.sv
// self-checking bench for the fan drive mode control block
`timescale 1ns/1ps
`default_nettype none
module fsmc_fan_control_tb;
  typedef struct {logic [7:0] a; logic [7:0] w; logic wr; logic [7:0] e;} fsmc_row_t;
  logic        mclk, reset, wrStb, rdStb, autoUpdate, pwmOut, irq, tachIn, fanRun;
  logic [7:0]  addr, wrData, rdData, autoDuty, rv;
  logic [15:0] fanHalf;
  int          bad_count, total_checks, cyc, h;
  fsmc_row_t   rows [12] = '{
    '{8'h00, 8'h00, 1'b0, 8'h00}, '{8'h10, 8'h00, 1'b0, 8'hFF},
    '{8'h20, 8'h00, 1'b0, 8'h00}, '{8'h22, 8'h00, 1'b0, 8'h00},
    '{8'h23, 8'h00, 1'b0, 8'h10}, '{8'h40, 8'h00, 1'b0, 8'h00},
    '{8'h41, 8'h00, 1'b0, 8'h00}, '{8'h55, 8'hAA, 1'b1, 8'h00},
    '{8'h23, 8'hFF, 1'b1, 8'hFD}, '{8'h23, 8'h10, 1'b1, 8'h10},
    '{8'h10, 8'h5A, 1'b1, 8'h5A}, '{8'h41, 8'h00, 1'b1, 8'h00}};

  fsmc_fan_control i_dut (.mclk(mclk), .reset(reset), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .tachIn(tachIn), .autoDuty(autoDuty), .autoUpdate(autoUpdate),
    .pwmOut(pwmOut), .irq(irq));
  fsmc_fan_model i_fan (.mclk(mclk), .run(fanRun), .halfPer(fanHalf), .tach(tachIn));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(negedge mclk);
    rv = rdData;
  endtask
  // settle one pwm period, then count high cycles over the next
  task automatic slots(output logic [7:0] s);
    h = 0;
    repeat (960) @(posedge mclk);
    repeat (960) begin
      @(negedge mclk);
      if (pwmOut === 1'b1) h++;
    end
    s = 8'(h / 4);
  endtask
  // poll status until the given bit shows, bounded
  task automatic waitSt(input int b);
    rv = 8'h00;
    for (int i = 0; i < 12000 && rv[b] !== 1'b1; i++) rd(8'h40);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // bench clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 98000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    logic [7:0] s;
    reset = 1'b1;
    {wrStb, rdStb, autoUpdate, fanRun} = 4'h0;
    {addr, wrData, autoDuty} = 24'h00_0000;
    fanHalf = 16'h0384;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    chk({6'h00, pwmOut, irq}, 8'h00);
    // register table rows
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(rv, rows[i].e);
    end
    $display("test registers done");
    // every duty code, software duty path
    for (int c = 0; c < 16; c++) begin
      wr(8'h22, 8'(c));
      slots(s);
      chk(s, 8'(c * 16));
    end
    $display("test duty codes done");
    // normal mode: target is a limit, count over it flags failure
    wr(8'h10, 8'h02);
    wr(8'h40, 8'h03);
    fanRun <= 1'b1;
    waitSt(1);
    fanRun <= 1'b0;
    chk({7'h00, irq}, 8'h00);
    rd(8'h08);
    chk(8'(rv >= 8'h04 && rv <= 8'h05), 8'h01);
    wr(8'h41, 8'h02);
    repeat (3) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    wr(8'h40, 8'h03);
    repeat (3) @(posedge mclk);
    chk({7'h00, irq}, 8'h00);
    $display("test limit and interrupt done");
    // software sets range two and target before closed loop
    // software range
    wr(8'h20, 8'h40);
    fanHalf <= 16'h06F0; // fan speed kept above the code 08 speed
    wr(8'h10, 8'h00); // software target count
    wr(8'h22, 8'h00);
    wr(8'h00, 8'h20);
    slots(s);
    chk(s, 8'd180);
    wr(8'h40, 8'h03);
    fanRun <= 1'b1;
    repeat (2) begin
      waitSt(0);
      chk(rv, 8'h01);
      wr(8'h40, 8'h01);
    end
    fanRun <= 1'b0;
    slots(s);
    chk(s, 8'd182);
    wr(8'h10, 8'hFF);
    wr(8'h40, 8'h03);
    fanRun <= 1'b1;
    waitSt(0);
    fanRun <= 1'b0;
    slots(s);
    chk(s, 8'd181);
    $display("test rpm loop done");
    // auto mode, back to software, then filtered ramp
    autoDuty <= 8'd100;
    wr(8'h00, 8'h80);
    slots(s);
    chk(s, 8'd100);
    wr(8'h22, 8'h05);
    wr(8'h00, 8'h00);
    slots(s);
    chk(s, 8'd80);
    wr(8'h00, 8'h08);
    slots(s);
    chk(s, 8'd160);
    wr(8'h23, 8'h61);
    wr(8'h00, 8'h80);
    repeat (2) begin
      @(posedge mclk);
      autoUpdate <= 1'b1;
      @(posedge mclk);
      autoUpdate <= 1'b0;
    end
    slots(s);
    chk(s, 8'd96);
    $display("test auto modes done");
    // reset in mid-run returns registers to defaults
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    chk({6'h00, pwmOut, irq}, 8'h00);
    rd(8'h23);
    chk(rv, 8'h10);
    rd(8'h00);
    chk(rv, 8'h00);
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
